//--- clock_ctrl_params.svh
// constants for the system clock divider control block
// assumes inclusion by bare name from the design files and the bench
`ifndef CLOCK_CTRL_PARAMS_SVH
`define CLOCK_CTRL_PARAMS_SVH
// ---------------------------------------------------------------
// register byte addresses
// ---------------------------------------------------------------
`define ADDR_PRESCALE_TB0 12'h000
`define ADDR_DISP_BUZ 12'h004
`define ADDR_RESET_CAUSE 12'h008
`define ADDR_XTAL_TB1 12'h00C
`define ADDR_CLOCK_MODE 12'h010
`define ADDR_STATUS 12'h014
// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define RST_PRESCALE_TB0 8'h00
`define RST_DISP_BUZ 8'h01
`define RST_XTAL_TB1 8'h07
// ---------------------------------------------------------------
// write masks of implemented bits
// ---------------------------------------------------------------
`define MASK_PRESCALE_TB0 8'hF0
`define MASK_DISP_BUZ 8'hFF
`define MASK_RESET_CAUSE 8'h07
`define MASK_XTAL_TB1 8'h17
// ---------------------------------------------------------------
// divider tap bases
// ---------------------------------------------------------------
`define TB0_BASE_EXP 5'd12
`define TB1_BASE_EXP 5'd8
`define DISP_BASE_EXP 5'd2
`define BUZ_BASE_EXP 5'd2
`define FS_CNT_W 16
`define AXI_RESP_OKAY 2'h0
`define AXI_RESP_SLVERR 2'h2
`endif

//--- clock_ctrl_pkg.sv
// types for the system clock divider control block
// assumes the params header is on the include path
package clock_ctrl_pkg;
  typedef enum logic [1:0] {SRC_SYS, SRC_SLOW_XTAL, SRC_FREQ_DIV, SRC_UNDEF} prescale_src_e;
  typedef enum logic [1:0] {OSC_FAST_XTAL, OSC_EXT_RC, OSC_FAST_IRC} fast_osc_e;
  typedef enum logic [1:0] {IRC_4MHZ, IRC_8MHZ, IRC_12MHZ} irc_freq_e;
  typedef enum logic [1:0] {FS_SLOW_IRC, FS_SLOW_XTAL, FS_SYS_DIV4} fs_src_e;
  typedef enum {WR_IDLE, WR_RESP} wr_state_e;
  typedef enum {RD_IDLE, RD_RESP} rd_state_e;
endpackage

//--- fs_tap_counter.sv
// free running binary counter on the time-base clock enable
// assumes fs arrives as a one-cycle enable synchronous to clk_in
`timescale 1ns/10ps
`default_nettype none
`include "clock_ctrl_params.svh"
module fs_tap_counter (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic fs_tick_in,
  output logic [`FS_CNT_W-1:0] count_out
);
  typedef struct packed {
    logic [`FS_CNT_W-1:0] cnt;
  } cnt_s;
  cnt_s st_q;
  cnt_s st_d;

  // advance once per fs tick
  always_comb begin
    st_d = st_q;
    if (fs_tick_in) begin
      st_d.cnt = st_q.cnt + `FS_CNT_W'(1);
    end
  end

  // registered state
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign count_out = st_q.cnt;
endmodule
`default_nettype wire

//--- clock_ctrl.sv
// system clock divider and system control registers over axi4-lite
// assumes fs, timer and divider clocks arrive as enables on clk_in
//
// Function
// - prescaler source 00 system clock, 01 slow crystal, 10 divider output
// - timer zero uses prescaler output, except code 10 uses system clock
// - with a pulse channel on, upper source bit alone picks system or divider
// - time base 0 picks fs over 2^12..2^15
// - display clock picks fs over 2^2..2^8, code 111 reserved
// - buzzer picks fs over 2^2..2^9
// - halt-keep bit 1 keeps slow crystal in halt, resets to 1
// - undervoltage reset flag set by hardware, software only clears
// - undervoltage setting flag, software only clears, powers up 0
// - watchdog setting flag, software only clears, resets 0
// - crystal power bit 0 quick start, 1 low power, resets 0
// - time base 1 picks fs over 2^8..2^15, resets to 111
// - unimplemented bits read zero and ignore writes
// - oscillators also clock watchdog and time bases
// - oscillator type fixed by configuration inputs
// - fast internal rc offers 4, 8 or 12 mhz by configuration
// - slow crystal only together with a fast source
// - external rc frees second oscillator pin for io
// - configuration picks crystal or io for slow crystal pins
// - clock mode bit picks fast or slow system clock, slow only with slow crystal configured
// - slow internal rc runs on undervoltage, watchdog or fs need
//
// Implementation choices: the register offsets and the AXI4-Lite register port.
`timescale 1ns/10ps
`default_nettype none
`include "clock_ctrl_params.svh"
module clock_ctrl
  import clock_ctrl_pkg::*;
(
  input wire logic clk_in,
  input wire logic nrst_in,
  // axi4-lite slave
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // configuration options
  input wire logic [1:0] cfg_fast_osc_in,
  input wire logic [1:0] cfg_irc_freq_in,
  input wire logic cfg_slow_xtal_used_in,
  input wire logic [1:0] cfg_fs_src_in,
  // system events and enables
  input wire logic fs_tick_in,
  input wire logic freq_div_tick_in,
  input wire logic slow_xtal_tick_in,
  input wire logic pulse_chan0_enable_in,
  input wire logic pulse_chan1_enable_in,
  input wire logic halt_in,
  input wire logic undervoltage_reset_in,
  input wire logic undervoltage_setting_reset_in,
  input wire logic watchdog_setting_reset_in,
  input wire logic undervoltage_enabled_in,
  input wire logic watchdog_enabled_in,
  input wire logic buzzer_gpio_in,
  // outputs
  output logic prescaler_tick_out,
  output logic timer_zero_tick_out,
  output logic timebase0_tick_out,
  output logic timebase1_tick_out,
  output logic display_clk_out,
  output logic buzzer_pin_out,
  output logic fast_osc_run_out,
  output logic slow_xtal_run_out,
  output logic slow_xtal_low_power_out,
  output logic slow_irc_run_out,
  output logic system_clock_slow_out,
  output logic oscillator_pin_b_is_io_out,
  output logic slow_crystal_pins_are_io_out,
  output logic [1:0] irc_freq_out,
  output logic wdt_clk_tick_out,
  output logic timebase_clk_tick_out
);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [7:0] prescale_tb0;
    logic [7:0] disp_buz;
    logic [2:0] flags;
    logic [7:0] xtal_tb1;
    logic system_clock_mode_bit;
    logic [`FS_CNT_W-1:0] cnt_prev;
    wr_state_e wr_st;
    rd_state_e rd_st;
    logic aw_got;
    logic w_got;
    logic [11:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic [1:0] bresp;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } ctrl_s;
  ctrl_s st_q;
  ctrl_s st_d;
  logic [`FS_CNT_W-1:0] fs_count;
  logic [`FS_CNT_W-1:0] rise;

  fs_tap_counter u_cnt (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .fs_tick_in(fs_tick_in),
    .count_out(fs_count)
  );

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // pick a counter stage; exponent n means stage n-1
  function automatic logic tap(input logic [`FS_CNT_W-1:0] r, input logic [4:0] e);
    logic [4:0] i;
    i = e - 5'd1;
    return r[i[3:0]];
  endfunction

  // readable word of a register address
  function automatic logic [31:0] rd_word(input ctrl_s s, input logic [11:0] a, input logic slow);
    rd_word = 32'h0000_0000;
    case (a)
      `ADDR_PRESCALE_TB0: rd_word = {24'h0, s.prescale_tb0 & `MASK_PRESCALE_TB0};
      `ADDR_DISP_BUZ: rd_word = {24'h0, s.disp_buz};
      `ADDR_RESET_CAUSE: rd_word = {29'h0, s.flags};
      `ADDR_XTAL_TB1: rd_word = {24'h0, s.xtal_tb1 & `MASK_XTAL_TB1};
      `ADDR_CLOCK_MODE: rd_word = {31'h0, s.system_clock_mode_bit};
      `ADDR_STATUS: rd_word = {31'h0, slow};
      default: rd_word = 32'h0000_0000;
    endcase
  endfunction

  // address is mapped
  function automatic logic mapped(input logic [11:0] a);
    return (a == `ADDR_PRESCALE_TB0) || (a == `ADDR_DISP_BUZ) || (a == `ADDR_RESET_CAUSE) ||
           (a == `ADDR_XTAL_TB1) || (a == `ADDR_CLOCK_MODE) || (a == `ADDR_STATUS);
  endfunction

  // rising stages of the counter, one-cycle pulses
  assign rise = fs_count & ~st_q.cnt_prev;

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  logic wr_fire;
  logic [7:0] wbyte;
  always_comb begin
    st_d = st_q;
    st_d.cnt_prev = fs_count;
    wr_fire = 1'b0;
    wbyte = st_q.wdata[7:0];
    // write channel capture in either order
    if (st_q.wr_st == WR_IDLE) begin
      if (s_axi_awvalid && !st_q.aw_got) begin
        st_d.aw_got = 1'b1;
        st_d.awaddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && !st_q.w_got) begin
        st_d.w_got = 1'b1;
        st_d.wdata = s_axi_wdata;
        st_d.wstrb = s_axi_wstrb;
      end
      if (st_q.aw_got && st_q.w_got) begin
        wr_fire = st_q.wstrb[0];
        st_d.bresp = mapped(st_q.awaddr) ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
        st_d.wr_st = WR_RESP;
      end
    end else begin
      if (s_axi_bready) begin
        st_d.wr_st = WR_IDLE;
        st_d.aw_got = 1'b0;
        st_d.w_got = 1'b0;
      end
    end
    if (wr_fire) begin
      case (st_q.awaddr)
        `ADDR_PRESCALE_TB0: st_d.prescale_tb0 = wbyte & `MASK_PRESCALE_TB0;
        `ADDR_DISP_BUZ: st_d.disp_buz = wbyte & `MASK_DISP_BUZ;
        `ADDR_XTAL_TB1: st_d.xtal_tb1 = wbyte & `MASK_XTAL_TB1;
        `ADDR_CLOCK_MODE: st_d.system_clock_mode_bit = wbyte[0];
        default: st_d.system_clock_mode_bit = st_d.system_clock_mode_bit;
      endcase
    end
    if (wr_fire && st_q.awaddr == `ADDR_RESET_CAUSE) begin
      st_d.flags = st_q.flags & wbyte[2:0];
    end
    st_d.flags = st_d.flags | {undervoltage_reset_in, undervoltage_setting_reset_in,
                               watchdog_setting_reset_in};
    // read channel
    if (st_q.rd_st == RD_IDLE) begin
      if (s_axi_arvalid) begin
        st_d.rdata = rd_word(st_q, s_axi_araddr, system_clock_slow_out);
        st_d.rresp = mapped(s_axi_araddr) ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
        st_d.rd_st = RD_RESP;
      end
    end else begin
      if (s_axi_rready) begin
        st_d.rd_st = RD_IDLE;
      end
    end
  end

  // register all state
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      st_q <= '0;
      st_q.prescale_tb0 <= `RST_PRESCALE_TB0;
      st_q.disp_buz <= `RST_DISP_BUZ;
      st_q.xtal_tb1 <= `RST_XTAL_TB1;
      st_q.wr_st <= WR_IDLE;
      st_q.rd_st <= RD_IDLE;
    end else begin
      st_q <= st_d;
    end
  end

  // ---------------------------------------------------------------
  // bus handshakes
  // ---------------------------------------------------------------
  assign s_axi_awready = (st_q.wr_st == WR_IDLE) && !st_q.aw_got;
  assign s_axi_wready = (st_q.wr_st == WR_IDLE) && !st_q.w_got;
  assign s_axi_bvalid = (st_q.wr_st == WR_RESP);
  assign s_axi_bresp = st_q.bresp;
  assign s_axi_arready = (st_q.rd_st == RD_IDLE);
  assign s_axi_rvalid = (st_q.rd_st == RD_RESP);
  assign s_axi_rdata = st_q.rdata;
  assign s_axi_rresp = st_q.rresp;

  // ---------------------------------------------------------------
  // prescaler and timer zero clocking
  // ---------------------------------------------------------------
  logic [1:0] src;
  logic pulse_on;
  logic prescaler_src_tick;
  assign src = st_q.prescale_tb0[7:6];
  assign pulse_on = pulse_chan0_enable_in | pulse_chan1_enable_in;
  always_comb begin
    prescaler_src_tick = 1'b0;
    if (pulse_on) begin
      prescaler_src_tick = src[1] ? freq_div_tick_in : 1'b1;
    end else begin
      case (src)
        2'h0: prescaler_src_tick = 1'b1;
        2'h1: prescaler_src_tick = slow_xtal_tick_in;
        2'h2: prescaler_src_tick = freq_div_tick_in;
        default: prescaler_src_tick = 1'b0;
      endcase
    end
  end
  assign prescaler_tick_out = prescaler_src_tick;
  assign timer_zero_tick_out = (src == 2'h2) ? 1'b1 : prescaler_src_tick;

  // ---------------------------------------------------------------
  // divider taps
  // ---------------------------------------------------------------
  // time base 0 and time base 1
  assign timebase0_tick_out = tap(rise, `TB0_BASE_EXP + {3'h0, st_q.prescale_tb0[5:4]});
  assign timebase1_tick_out = tap(rise, `TB1_BASE_EXP + {2'h0, st_q.xtal_tb1[2:0]});
  // display clock, reserved code holds low
  assign display_clk_out = (st_q.disp_buz[7:5] == 3'h7) ? 1'b0 :
                           tap(fs_count, `DISP_BASE_EXP + {2'h0, st_q.disp_buz[7:5]});
  assign buzzer_pin_out = st_q.disp_buz[1] ? tap(fs_count, `BUZ_BASE_EXP + {2'h0, st_q.disp_buz[4:2]})
                                           : buzzer_gpio_in;

  // ---------------------------------------------------------------
  // oscillator control
  // ---------------------------------------------------------------
  // clock mode, fast stops in slow mode and halt
  assign system_clock_slow_out = st_q.system_clock_mode_bit & cfg_slow_xtal_used_in;
  assign fast_osc_run_out = !halt_in && !system_clock_slow_out;
  // slow crystal runs only when configured, and in halt only with the keep bit set
  assign slow_xtal_run_out = cfg_slow_xtal_used_in && (!halt_in || st_q.disp_buz[0]);
  assign slow_xtal_low_power_out = st_q.xtal_tb1[4];
  assign slow_irc_run_out = undervoltage_enabled_in || watchdog_enabled_in ||
                            (cfg_fs_src_in == FS_SLOW_IRC);
  assign oscillator_pin_b_is_io_out = (cfg_fast_osc_in == OSC_EXT_RC) ||
                                      (cfg_fast_osc_in == OSC_FAST_IRC);
  assign slow_crystal_pins_are_io_out = !cfg_slow_xtal_used_in;
  assign irc_freq_out = (cfg_irc_freq_in == 2'h3) ? IRC_4MHZ : cfg_irc_freq_in;
  assign wdt_clk_tick_out = fs_tick_in;
  assign timebase_clk_tick_out = fs_tick_in;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  property p_flag_set;
    @(posedge clk_in) disable iff (!nrst_in)
      undervoltage_reset_in |=> st_q.flags[2];
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("flag not set");

  property p_wdt_flag_hold;
    @(posedge clk_in) disable iff (!nrst_in)
      (st_q.flags[0] && !(wr_fire && st_q.awaddr == `ADDR_RESET_CAUSE)) |=> st_q.flags[0];
  endproperty
  a_wdt_flag_hold: assert property (p_wdt_flag_hold) else $error("flag lost");

  property p_no_sw_set;
    @(posedge clk_in) disable iff (!nrst_in)
      (!st_q.flags[1] && !undervoltage_setting_reset_in) |=> !st_q.flags[1];
  endproperty
  a_no_sw_set: assert property (p_no_sw_set) else $error("flag set by software");

  property p_timer_sys;
    @(posedge clk_in) disable iff (!nrst_in)
      (src == 2'h2) |-> timer_zero_tick_out;
  endproperty
  a_timer_sys: assert property (p_timer_sys) else $error("timer not on system clock");

  property p_pwm_src;
    @(posedge clk_in) disable iff (!nrst_in)
      (pulse_on && !src[1]) |-> prescaler_tick_out;
  endproperty
  a_pwm_src: assert property (p_pwm_src) else $error("prescaler source wrong");

  property p_reserved_zero;
    @(posedge clk_in) disable iff (!nrst_in)
      st_q.prescale_tb0[3:0] == 4'h0 && st_q.xtal_tb1[7:5] == 3'h0 && !st_q.xtal_tb1[3];
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit set");

  property p_keep;
    @(posedge clk_in) disable iff (!nrst_in)
      (halt_in && cfg_slow_xtal_used_in && st_q.disp_buz[0]) |-> slow_xtal_run_out;
  endproperty
  a_keep: assert property (p_keep) else $error("crystal stopped in idle");

  property p_rresp;
    @(posedge clk_in) disable iff (!nrst_in)
      (s_axi_arvalid && s_axi_arready) |=> s_axi_rvalid && (s_axi_rdata[31:8] == 24'h000000);
  endproperty
  a_rresp: assert property (p_rresp) else $error("read answer late");

  c_write: cover property (@(posedge clk_in) disable iff (!nrst_in) s_axi_bvalid && s_axi_bready);
  c_read: cover property (@(posedge clk_in) disable iff (!nrst_in) s_axi_rvalid && s_axi_rready);
  c_halt_idle: cover property (@(posedge clk_in) disable iff (!nrst_in) halt_in && slow_xtal_run_out);
endmodule
`default_nettype wire

//--- clock_ctrl_tb.sv
// self-checking bench for the clock divider control block
// assumes design, package and params header compiled first
`timescale 1ns/10ps
`default_nettype none
`include "clock_ctrl_params.svh"
module clock_ctrl_tb;
  import clock_ctrl_pkg::*;
  // ---------------------------------------------------------------
  // stimulus, observed outputs and model state
  // ---------------------------------------------------------------
  logic clk_in = 1'b0;
  logic nrst_in = 1'b0;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0] wstrb = 4'hF;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [1:0] cfg_fast_osc = 2'h0, cfg_irc = 2'h0, cfg_fs = 2'h0;
  logic cfg_xt_used = 1'b0, fs_tick = 1'b0, fdiv_tick = 1'b0, xt_tick = 1'b0, pc0 = 1'b0, pc1 = 1'b0;
  logic halt = 1'b0, uv_rst = 1'b0, uvs_rst = 1'b0, wd_rst = 1'b0, uv_en = 1'b0, wd_en = 1'b0, gpio = 1'b0;
  logic pre_o, tz_o, tb0_o, tb1_o, disp_o, buz_o, xt_run_o, xt_lp_o, irc_run_o, pinb_io_o, xtpins_io_o;
  logic wdt_o, tbclk_o, fast_run_o, slow_sys_o;
  logic [1:0] irc_freq_o;
  logic [7:0] regm [0:5] = '{8'h00, 8'h01, 8'h00, 8'h07, 8'h00, 8'h00};
  logic [15:0] mcnt = 16'h0000;
  int mismatches = 0;
  int n_compared = 0;

  clock_ctrl clock_ctrl_inst (.clk_in(clk_in), .nrst_in(nrst_in),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .cfg_fast_osc_in(cfg_fast_osc), .cfg_irc_freq_in(cfg_irc),
    .cfg_slow_xtal_used_in(cfg_xt_used), .cfg_fs_src_in(cfg_fs), .fs_tick_in(fs_tick),
    .freq_div_tick_in(fdiv_tick), .slow_xtal_tick_in(xt_tick), .pulse_chan0_enable_in(pc0),
    .pulse_chan1_enable_in(pc1), .halt_in(halt), .undervoltage_reset_in(uv_rst),
    .undervoltage_setting_reset_in(uvs_rst), .watchdog_setting_reset_in(wd_rst),
    .undervoltage_enabled_in(uv_en), .watchdog_enabled_in(wd_en), .buzzer_gpio_in(gpio),
    .prescaler_tick_out(pre_o), .timer_zero_tick_out(tz_o), .timebase0_tick_out(tb0_o),
    .timebase1_tick_out(tb1_o), .display_clk_out(disp_o), .buzzer_pin_out(buz_o), .fast_osc_run_out(fast_run_o),
    .slow_xtal_run_out(xt_run_o), .slow_xtal_low_power_out(xt_lp_o), .slow_irc_run_out(irc_run_o),
    .system_clock_slow_out(slow_sys_o), .oscillator_pin_b_is_io_out(pinb_io_o),
    .slow_crystal_pins_are_io_out(xtpins_io_o), .irc_freq_out(irc_freq_o), .wdt_clk_tick_out(wdt_o),
    .timebase_clk_tick_out(tbclk_o));

  // clock and the model's free-running fs counter
  always #50 clk_in = ~clk_in;
  always @(posedge clk_in) begin
    if (!nrst_in) mcnt <= 16'h0000;
    else if (fs_tick) mcnt <= mcnt + 16'h0001;
  end

  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic end_of_test;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // write: address and data offered together, bready held until bvalid
  task automatic axi_wr(input logic [11:0] a, input logic [7:0] d, input logic [3:0] s, output logic [1:0] r);
    logic [31:0] u = $urandom;
    @(posedge clk_in);
    awaddr <= a; wdata <= {u[31:8], d}; wstrb <= s;
    awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    forever begin
      @(posedge clk_in);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) begin
        r = bresp; bready <= 1'b0; break;
      end
    end
  endtask

  task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk_in);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    forever begin
      @(posedge clk_in);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) begin
        d = rdata; r = rresp; rready <= 1'b0; break;
      end
    end
  endtask

  // model write of the implemented bits, then read back
  task automatic wr_chk(input int idx, input logic [7:0] d);
    logic [1:0] r;
    logic [31:0] q;
    axi_wr(12'(idx * 4), d, 4'hF, r);
    chk("write resp", `AXI_RESP_OKAY, r);
    case (idx)
      0: regm[0] = d & `MASK_PRESCALE_TB0;
      1: regm[1] = d;
      2: regm[2] = regm[2] & d & `MASK_RESET_CAUSE;
      3: regm[3] = d & `MASK_XTAL_TB1;
      4: regm[4] = d & 8'h01;
      default: ;
    endcase
    axi_rd(12'(idx * 4), q, r);
    chk("read data", {24'h0, regm[idx]}, q);
  endtask

  task automatic pulse_flags(input logic [2:0] f);
    @(posedge clk_in);
    {uv_rst, uvs_rst, wd_rst} <= f;
    @(posedge clk_in);
    {uv_rst, uvs_rst, wd_rst} <= 3'h0;
    regm[2] = regm[2] | {5'h00, f};
  endtask

  // combinational outputs against the model, at a settled point
  task automatic chk_outs;
    logic [1:0] src;
    logic pre;
    logic [2:0] dc, bc;
    src = regm[0][7:6];
    if (pc0 | pc1) src = {src[1], 1'b0};
    pre = (src == 2'd0) ? 1'b1 : (src == 2'd1) ? xt_tick : (src == 2'd2) ? fdiv_tick : 1'b0;
    dc = regm[1][7:5];
    bc = regm[1][4:2];
    chk("prescaler tick", pre, pre_o);
    chk("timer zero tick", (regm[0][7:6] == 2'd2) ? 1'b1 : pre, tz_o);
    chk("display clock", (dc == 3'd7) ? 1'b0 : mcnt[dc + 1], disp_o);
    chk("buzzer pin", regm[1][1] ? mcnt[bc + 1] : gpio, buz_o);
    chk("slow crystal run", cfg_xt_used & (~halt | regm[1][0]), xt_run_o);
    chk("crystal low power", regm[3][4], xt_lp_o);
    chk("slow irc run", uv_en | wd_en | (cfg_fs == 2'd0), irc_run_o);
    chk("pin b io", (cfg_fast_osc == 2'd1) || (cfg_fast_osc == 2'd2), pinb_io_o);
    chk("slow pins io", !cfg_xt_used, xtpins_io_o);
    chk("irc freq", (cfg_irc == 2'd3) ? 2'd0 : cfg_irc, irc_freq_o);
    chk("fs copies", {2{fs_tick}}, {wdt_o, tbclk_o});
    chk("slow system clock", regm[4][0] && cfg_xt_used, slow_sys_o);
    chk("fast osc run", !halt && !(regm[4][0] && cfg_xt_used), fast_run_o);
  endtask

  // counts tick pulses over two periods, window edges far from the stage edge
  task automatic count_ticks(input bit one, input int k);
    int n = 0;
    do @(negedge clk_in); while ((int'(mcnt) % (1 << k)) != 0);
    repeat (2 << k) begin
      @(negedge clk_in);
      if ((one ? tb1_o : tb0_o) === 1'b1) n++;
    end
    chk("time base ticks", 2, n);
  endtask

  // ---------------------------------------------------------------
  // watchdog and main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (90000) @(posedge clk_in);
    mismatches++;
    $display("watchdog expired");
    end_of_test();
  end

  initial begin
    logic [1:0] r;
    logic [31:0] q;
    logic [7:0] d;
    void'($urandom(6));
    repeat (12) @(posedge clk_in);
    nrst_in <= 1'b1;
    @(posedge clk_in);
    for (int i = 0; i < 6; i++) begin
      axi_rd(12'(i * 4), q, r);
      chk("reset value", {24'h0, regm[i]}, q);
    end
    axi_wr(12'h020, 8'hFF, 4'hF, r);
    chk("unmapped write resp", `AXI_RESP_SLVERR, r);
    axi_rd(12'h020, q, r);
    chk("unmapped read resp", {30'h0, `AXI_RESP_SLVERR}, {30'h0, r});
    chk("unmapped read data", 32'h0, q);
    axi_wr(`ADDR_DISP_BUZ, 8'hAA, 4'hE, r);
    chk("strobe write resp", {30'h0, `AXI_RESP_OKAY}, {30'h0, r});
    axi_rd(`ADDR_DISP_BUZ, q, r);
    chk("strobe write ignored", {24'h0, regm[1]}, q);
    wr_chk(5, 8'hFF);
    $display("registers done");
    pulse_flags(3'h4);
    wr_chk(2, 8'hFF);
    pulse_flags(3'h3);
    wr_chk(2, 8'h05);
    wr_chk(2, 8'h00);
    $display("reset flags done");
    for (int i = 0; i < 400; i++) begin
      @(posedge clk_in);
      {fs_tick, fdiv_tick, xt_tick, pc0, pc1, halt, uv_en, wd_en, gpio, cfg_xt_used} <= 10'($urandom);
      cfg_fast_osc <= 2'($urandom_range(2));
      cfg_fs <= 2'($urandom_range(2));
      cfg_irc <= 2'($urandom);
      @(negedge clk_in);
      chk_outs();
      if (i % 25 == 0) begin
        d = 8'($urandom);
        if (d[7:6] == 2'd3) d[7] = 1'b0;
        wr_chk($urandom_range(4), d);
      end
    end
    $display("outputs done");
    @(posedge clk_in);
    fs_tick <= 1'b1;
    for (int c = 0; c < 8; c++) begin
      wr_chk(1, {3'(c), 3'(7 - c), 2'(c)});
      repeat (40) begin
        @(negedge clk_in);
        chk_outs();
      end
    end
    for (int c = 0; c < 5; c++) begin
      wr_chk(3, 8'(c));
      count_ticks(1'b1, 8 + c);
    end
    for (int c = 0; c < 2; c++) begin
      wr_chk(0, 8'(c << 4));
      count_ticks(1'b0, 12 + c);
    end
    $display("time bases done");
    end_of_test();
  end
endmodule
`default_nettype wire
